/* rmss_pkg.sv */
// shared constants and types for the reset mode strap sampler
`default_nettype none
package rmss_pkg;
  // timing: internal clock runs at twice the bus clock
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BUS_PERIOD_PS = 10000;
  localparam int STD_PRECHARGE_PS = BUS_PERIOD_PS / 2;
  localparam int EXT_PRECHARGE_PS = BUS_PERIOD_PS;
  localparam int PCH_CNT_W = 4;
  localparam int STD_PRECHARGE_CYC_I =
    (STD_PRECHARGE_PS / CLK_PERIOD_PS < 1) ? 1 :
    STD_PRECHARGE_PS / CLK_PERIOD_PS;
  localparam int EXT_PRECHARGE_CYC_I =
    (EXT_PRECHARGE_PS / CLK_PERIOD_PS < 1) ? 1 :
    EXT_PRECHARGE_PS / CLK_PERIOD_PS;
  localparam logic [PCH_CNT_W-1:0] STD_PRECHARGE_CYC =
    PCH_CNT_W'(STD_PRECHARGE_CYC_I);
  localparam logic [PCH_CNT_W-1:0] EXT_PRECHARGE_CYC =
    PCH_CNT_W'(EXT_PRECHARGE_CYC_I);
  localparam logic [PCH_CNT_W-1:0] PCH_CNT_ZERO = PCH_CNT_W'(0);
  localparam logic [PCH_CNT_W-1:0] PCH_CNT_ONE = PCH_CNT_W'(1);

  // number of precharged bus handshake lines and their slots
  localparam int NUM_PCH = 3;
  localparam int PCH_ADDR_BUSY = 0;
  localparam int PCH_DATA_BUSY = 1;
  localparam int PCH_ADDR_RETRY = 2;

  // reset values of latched modes
  localparam logic WIDE_BUS_RST = 1'h1;
  localparam logic RETRY_RST = 1'h0;
  localparam logic [2:0] FACTORY_STRAPS_RST = 3'h7;
  localparam logic EXT_PCH_RST = 1'h0;

  // factory strap vector positions
  localparam int FACT_DATA_BUS_DISABLE_N_BIT = 0;
  localparam int FACT_WONLY_BIT = 1;
  localparam int FACT_L2CLK_BIT = 2;

  typedef enum logic [1:0] {
    RMSS_IO_3V3,
    RMSS_IO_2V5,
    RMSS_IO_1V8,
    RMSS_IO_INVALID
  } rmss_io_mode_type;

  typedef enum logic [1:0] {
    RMSS_Q_IDLE,
    RMSS_Q_REQ,
    RMSS_Q_HALT
  } rmss_qstate_type;
endpackage
`default_nettype wire

/* rmss_pch_if.sv */
// control and pin signals between the top and one precharge driver
`timescale 1ns/1ps
`default_nettype none
interface rmss_pch_if;
  logic assert_req;
  logic extended;
  logic pin_out;
  logic pin_oe;
  modport ctrl (output assert_req, output extended,
                input pin_out, input pin_oe);
  modport drv (input assert_req, input extended,
               output pin_out, output pin_oe);
endinterface
`default_nettype wire

/* rmss_precharge.sv */
// drives one shared active-low line: assert, precharge high, release
`timescale 1ns/1ps
`default_nettype none
module rmss_precharge
  import rmss_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // control and pin
  rmss_pch_if.drv pch
);
  logic [PCH_CNT_W-1:0] count;
  logic [PCH_CNT_W-1:0] next_count;
  logic next_pin_out;
  logic next_pin_oe;
  logic active;
  logic [PCH_CNT_W-1:0] pch_len;

  assign pch_len = pch.extended ? EXT_PRECHARGE_CYC
                                : STD_PRECHARGE_CYC;

  always_comb begin
    next_count = count;
    next_pin_out = 1'b1;
    next_pin_oe = 1'b0;
    if (pch.assert_req) begin
      next_count = pch_len;
      next_pin_out = 1'b0;
      next_pin_oe = 1'b1;
    end else if (active && count != PCH_CNT_ZERO) begin
      // never float straight from low: drive high first
      next_count = count - PCH_CNT_ONE;
      next_pin_out = 1'b1;
      next_pin_oe = 1'b1;
    end else begin
      next_count = PCH_CNT_ZERO;
    end
  end

  assign active = pch.pin_oe;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= PCH_CNT_ZERO;
      pch.pin_out <= 1'b1;
      pch.pin_oe <= 1'b0;
    end else begin
      count <= next_count;
      pch.pin_out <= next_pin_out;
      pch.pin_oe <= next_pin_oe;
    end
  end
endmodule
`default_nettype wire

/* rmss_top.sv */
// reset mode strap sampler: latched modes, precharge lines, quiesce
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module rmss_top (
  // clock and hard reset (resetn_in is hard_reset_n)
  input wire logic clock_in,
  input wire logic resetn_in,
  // reset straps
  input wire logic tlb_sync_mode_strap_in,
  input wire logic data_retry_in,
  input wire logic data_bus_disable_n_in,
  input wire logic data_bus_write_only_in,
  input wire logic l2_test_clock_pin_in,
  input wire logic bus_voltage_select_in,
  input wire logic l1_test_clock_pin_in,
  // quiesce handshake
  input wire logic debug_stop_in,
  input wire logic quiesce_ack_n_in,
  output logic quiesce_req_n_out,
  output logic quiesced_out,
  // bus handshake requests from the bus interface
  input wire logic addr_bus_busy_req_in,
  input wire logic data_bus_busy_req_in,
  input wire logic addr_retry_req_in,
  // precharged bus handshake pins
  output logic addr_bus_busy_n_out,
  output logic addr_bus_busy_n_oe_out,
  output logic data_bus_busy_n_out,
  output logic data_bus_busy_n_oe_out,
  output logic addr_retry_n_out,
  output logic addr_retry_n_oe_out,
  // latched modes
  output logic modes_valid_out,
  output logic wide_bus_out,
  output logic data_retry_mode_out,
  output logic [2:0] factory_straps_out,
  output logic factory_mode_out,
  output rmss_pkg::rmss_io_mode_type io_mode_out,
  output logic extended_precharge_out
);
  import rmss_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // strap capture
  //////////////////////////////////////////////////////////////////////
  // async reset can only load constants, so straps are caught on the
  // first clock edge after release; pins are synchronous to the clock
  logic sampled;
  logic capture;
  logic [2:0] factory_pins;
  rmss_io_mode_type io_decode;

  assign capture = !sampled;
  assign factory_pins = {l2_test_clock_pin_in, data_bus_write_only_in,
                         data_bus_disable_n_in};

  // a low-low pin pair is not a legal mode; flag it rather than guess
  assign io_decode =
    ({bus_voltage_select_in, l1_test_clock_pin_in} == 2'h2) ? RMSS_IO_3V3 :
    ({bus_voltage_select_in, l1_test_clock_pin_in} == 2'h3) ? RMSS_IO_2V5 :
    ({bus_voltage_select_in, l1_test_clock_pin_in} == 2'h1) ? RMSS_IO_1V8 :
    RMSS_IO_INVALID;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sampled <= 1'b0;
      wide_bus_out <= WIDE_BUS_RST;
      data_retry_mode_out <= RETRY_RST;
      factory_straps_out <= FACTORY_STRAPS_RST;
      io_mode_out <= RMSS_IO_INVALID;
      extended_precharge_out <= EXT_PCH_RST;
    end else if (capture) begin
      sampled <= 1'b1;
      wide_bus_out <= tlb_sync_mode_strap_in;
      data_retry_mode_out <= data_retry_in;
      factory_straps_out <= factory_pins;
      io_mode_out <= io_decode;
      extended_precharge_out <= !quiesce_ack_n_in;
    end
  end

  // any strap low means a factory mode; normal systems keep them high
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      factory_mode_out <= 1'b0;
      modes_valid_out <= 1'b0;
    end else begin
      factory_mode_out <= capture ? !(&factory_pins)
                                  : factory_mode_out;
      modes_valid_out <= sampled;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // quiesce handshake for debug soft stop
  //////////////////////////////////////////////////////////////////////
  // ack is ignored until the straps are taken, so an ack tied to the
  // inverted hard reset cannot look like a quiesce confirmation
  rmss_qstate_type qstate;
  rmss_qstate_type next_qstate;

  always_comb begin
    next_qstate = qstate;
    unique case (qstate)
      RMSS_Q_IDLE: begin
        if (sampled && debug_stop_in) begin
          next_qstate = RMSS_Q_REQ;
        end
      end
      RMSS_Q_REQ: begin
        if (!debug_stop_in) begin
          next_qstate = RMSS_Q_IDLE;
        end else if (!quiesce_ack_n_in) begin
          next_qstate = RMSS_Q_HALT;
        end
      end
      RMSS_Q_HALT: begin
        if (!debug_stop_in) begin
          next_qstate = RMSS_Q_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      qstate <= RMSS_Q_IDLE;
      quiesce_req_n_out <= 1'b1;
      quiesced_out <= 1'b0;
    end else begin
      qstate <= next_qstate;
      quiesce_req_n_out <= (next_qstate == RMSS_Q_IDLE);
      quiesced_out <= (next_qstate == RMSS_Q_HALT);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // precharged handshake lines
  //////////////////////////////////////////////////////////////////////
  rmss_pch_if pch_bus [NUM_PCH] ();
  logic [NUM_PCH-1:0] pch_req;
  logic [NUM_PCH-1:0] pch_level;
  logic [NUM_PCH-1:0] pch_oe;

  assign pch_req[PCH_ADDR_BUSY] = addr_bus_busy_req_in;
  assign pch_req[PCH_DATA_BUSY] = data_bus_busy_req_in;
  assign pch_req[PCH_ADDR_RETRY] = addr_retry_req_in;

  for (genvar g = 0; g < NUM_PCH; g++) begin : g_pch
    assign pch_bus[g].assert_req = pch_req[g];
    assign pch_bus[g].extended = extended_precharge_out;
    assign pch_level[g] = pch_bus[g].pin_out;
    assign pch_oe[g] = pch_bus[g].pin_oe;
    rmss_precharge u_pch (
      .clock_in (clock_in),
      .resetn_in (resetn_in),
      .pch (pch_bus[g].drv)
    );
  end

  // pin values come straight from the driver flip-flops
  assign addr_bus_busy_n_out = pch_level[PCH_ADDR_BUSY];
  assign addr_bus_busy_n_oe_out = pch_oe[PCH_ADDR_BUSY];
  assign data_bus_busy_n_out = pch_level[PCH_DATA_BUSY];
  assign data_bus_busy_n_oe_out = pch_oe[PCH_DATA_BUSY];
  assign addr_retry_n_out = pch_level[PCH_ADDR_RETRY];
  assign addr_retry_n_oe_out = pch_oe[PCH_ADDR_RETRY];
endmodule
`default_nettype wire

/* rmss_sva.sv */
// assertion checker for the reset mode strap sampler
`timescale 1ns/1ps
`default_nettype none
module rmss_sva (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // reset straps
  input wire logic tlb_sync_mode_strap_in,
  input wire logic data_retry_in,
  input wire logic data_bus_disable_n_in,
  input wire logic data_bus_write_only_in,
  input wire logic l2_test_clock_pin_in,
  input wire logic bus_voltage_select_in,
  input wire logic l1_test_clock_pin_in,
  // handshakes
  input wire logic quiesce_ack_n_in,
  input wire logic quiesce_req_n_out,
  input wire logic quiesced_out,
  input wire logic addr_bus_busy_req_in,
  input wire logic data_bus_busy_req_in,
  input wire logic addr_bus_busy_n_out,
  input wire logic addr_bus_busy_n_oe_out,
  input wire logic data_bus_busy_n_out,
  input wire logic data_bus_busy_n_oe_out,
  // latched modes
  input wire logic modes_valid_out,
  input wire logic wide_bus_out,
  input wire logic data_retry_mode_out,
  input wire logic [2:0] factory_straps_out,
  input wire logic factory_mode_out,
  input wire logic extended_precharge_out,
  input wire rmss_pkg::rmss_io_mode_type io_mode_out
);
  import rmss_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_wide_capture: assert property (
    $rose(modes_valid_out) |->
    wide_bus_out == $past(tlb_sync_mode_strap_in, 2))
    else $error("bus width not taken from strap");
  a_retry_capture: assert property (
    $rose(modes_valid_out) |-> data_retry_mode_out == $past(data_retry_in, 2))
    else $error("retry mode not taken from strap");
  a_factory_capture: assert property ($rose(modes_valid_out) |->
    factory_straps_out == {$past(l2_test_clock_pin_in, 2),
    $past(data_bus_write_only_in, 2), $past(data_bus_disable_n_in, 2)})
    else $error("factory straps not taken at release");
  a_io_decode: assert property ($rose(modes_valid_out) |->
    io_mode_out == ($past(bus_voltage_select_in, 2) ?
    ($past(l1_test_clock_pin_in, 2) ? RMSS_IO_2V5 : RMSS_IO_3V3) :
    ($past(l1_test_clock_pin_in, 2) ? RMSS_IO_1V8 : RMSS_IO_INVALID)))
    else $error("io mode decode wrong");
  a_pch_select: assert property ($rose(modes_valid_out) |->
    extended_precharge_out == !$past(quiesce_ack_n_in, 2))
    else $error("precharge length not taken from ack");
  a_busy_drive: assert property (addr_bus_busy_req_in |=>
    !addr_bus_busy_n_out && addr_bus_busy_n_oe_out)
    else $error("busy line not driven low");
  a_pch_standard: assert property (!extended_precharge_out &&
    $fell(data_bus_busy_req_in) ##1 !data_bus_busy_req_in |=>
    $past(data_bus_busy_n_out) && $past(data_bus_busy_n_oe_out) &&
    !data_bus_busy_n_oe_out) else $error("standard precharge wrong");
  a_quiesce_ack: assert property ($rose(quiesced_out) |->
    !$past(quiesce_ack_n_in) && !$past(quiesce_req_n_out))
    else $error("quiesced without request and ack");
  a_modes_hold: assert property (modes_valid_out &&
    $past(modes_valid_out) |-> $stable({wide_bus_out, data_retry_mode_out,
    factory_straps_out, io_mode_out, extended_precharge_out}))
    else $error("latched modes changed");
  c_quiesce: cover property ($rose(quiesced_out));
  c_ext: cover property (
    $fell(data_bus_busy_req_in) && extended_precharge_out);
  c_std: cover property (
    $fell(data_bus_busy_req_in) && !extended_precharge_out);
endmodule
bind rmss_top rmss_sva rmss_sva_inst (.*);
`default_nettype wire

/* rmss_board.sv */
// board side: precharge strap on the ack pin, then quiesce acknowledge
`timescale 1ns/1ps
`default_nettype none
module rmss_board (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // board settings
  input wire logic ext_pch_in,
  input wire logic [3:0] ack_delay_in,
  // quiesce handshake
  input wire logic quiesce_req_n_in,
  output logic quiesce_ack_n_out
);
  logic [3:0] wait_cnt;
  // ack is a strap only while reset is low, a handshake afterwards
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      quiesce_ack_n_out <= !ext_pch_in;
      wait_cnt <= 4'h0;
    end else if (quiesce_req_n_in) begin
      quiesce_ack_n_out <= 1'b1;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == ack_delay_in) begin
      quiesce_ack_n_out <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* test_reset_mode_strap_sampler.sv */
// self-checking bench for the reset mode strap sampler
`timescale 1ns/1ps
`default_nettype none
module test_reset_mode_strap_sampler;
  import rmss_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, tlb = 1'b1, dr = 1'b0, ext = 1'b0;
  logic dbg = 1'b0;
  logic [2:0] fs = 3'h7, req = 3'h0;
  logic [1:0] vs = 2'h2;
  logic [3:0] dly = 4'h0;
  logic [7:0] seed = 8'h0a;
  logic [11:0] want;
  wire ack_n, req_n, qd, mv, wide, drm, fm, xp;
  wire [2:0] pin, oe, fct;
  rmss_io_mode_type io;
  wire [11:0] modes = {2'h0, mv, wide, drm, fct, fm, io, xp};
  int n_mismatch = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  rmss_top rmss_top_inst (.clock_in(clk), .resetn_in(rstn),
    .tlb_sync_mode_strap_in(tlb), .data_retry_in(dr),
    .data_bus_disable_n_in(fs[0]), .data_bus_write_only_in(fs[1]),
    .l2_test_clock_pin_in(fs[2]), .bus_voltage_select_in(vs[1]),
    .l1_test_clock_pin_in(vs[0]), .debug_stop_in(dbg),
    .quiesce_ack_n_in(ack_n), .quiesce_req_n_out(req_n), .quiesced_out(qd),
    .addr_bus_busy_req_in(req[0]), .data_bus_busy_req_in(req[1]),
    .addr_retry_req_in(req[2]), .addr_bus_busy_n_out(pin[0]),
    .addr_bus_busy_n_oe_out(oe[0]), .data_bus_busy_n_out(pin[1]),
    .data_bus_busy_n_oe_out(oe[1]), .addr_retry_n_out(pin[2]),
    .addr_retry_n_oe_out(oe[2]), .modes_valid_out(mv), .wide_bus_out(wide),
    .data_retry_mode_out(drm), .factory_straps_out(fct),
    .factory_mode_out(fm), .io_mode_out(io), .extended_precharge_out(xp));
  rmss_board rmss_board_inst (.clock_in(clk), .resetn_in(rstn),
    .ext_pch_in(ext), .ack_delay_in(dly), .quiesce_req_n_in(req_n),
    .quiesce_ack_n_out(ack_n));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic restart(input int k);
    int io_code;
    @(posedge clk) rstn <= 1'b0;
    seed = lfsr(seed);
    {tlb, dr, ext, dly} <= {seed[2:0], seed[7:4]};
    fs <= (k % 4 == 3) ? seed[5:3] : 3'h7;
    vs <= (seed % 3 == 0) ? 2'h2 : (seed % 3 == 1) ? 2'h3 : 2'h1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    io_code = (vs == 2'h2) ? 0 : (vs == 2'h3) ? 1 : 2;
    want = {2'h0, 1'b1, tlb, dr, fs, !(&fs), 2'(io_code), ext};
    repeat (2) @(posedge clk);
    #1 chk(modes, want);
    @(posedge clk) {tlb, dr, fs} <= ~{tlb, dr, fs};
    repeat (3) @(posedge clk);
    #1 chk(modes, want);
  endtask
  task automatic pch(input int i);
    @(posedge clk) req[i] <= 1'b1;
    @(posedge clk) req[i] <= 1'b0;
    #1 chk(12'({pin[i], oe[i]}), 12'h001);
    for (int j = 0; j < (ext ? 2 : 1); j++) begin
      @(posedge clk);
      #1 chk(12'({pin[i], oe[i]}), 12'h003);
    end
    @(posedge clk);
    #1 chk(12'(oe[i]), 12'h000);
  endtask
  task automatic quiesce;
    int t;
    @(posedge clk) dbg <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(12'({req_n, qd}), 12'h000);
    t = 0;
    while (qd !== 1'b1 && t < 40) begin
      @(posedge clk);
      #1 t++;
    end
    chk(12'(t), 12'(dly) + 12'h001);
    @(posedge clk) dbg <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(12'({req_n, qd}), 12'h002);
  endtask
  initial begin
    for (int k = 0; k < 8; k++) begin
      restart(k);
      for (int i = 0; i < 3; i++) pch(i);
      quiesce();
      $display("test %0d done", k);
    end
    complete_run();
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
